// File: rtl/pss_defines.svh
// constants for the serial pcs status register block
// What this block does
// - register valid only for tri-speed mac with sgmii or 1000base-x, else zero
// - bit 13 set on 1000base-x remote fault, fault kind in bits 9:8
// - remote fault bit sticks until a management read of phy status reg 1
// - remote fault bit has no meaning in sgmii mode
// - bit 12 reports negotiated duplex, one full, zero half
// - bits 11:10 report negotiated speed, 00/01/10 for 10/100/1000, 11 reserved
// - bits 9:8 hold received remote fault code on 1000base-x
// - sgmii mode, bit 7 shows external phy link state
// - 1000base-x mode, bit 7 held low
// - bit 6 set when received code group is not in 8b/10b tables
// - bit 5 set on running disparity error
// - bit 4 set on invalid data during config or idle ordered sets
// - bit 3 high while idles received, bit 2 while config sets received
// - bit 1 follows receive sync state, not qualified by auto-negotiation
// - bit 0 high when synced and auto-negotiation is either disabled or completed
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
`define PSS_ADDR_W        8
`define PSS_STATUS_OFF    8'h30
`define PSS_INT_STAT_OFF  8'h34
`define PSS_INT_MASK_OFF  8'h38
`define PSS_FLT_BIT       13
`define PSS_DUP_BIT       12
`define PSS_SPD_HI        11
`define PSS_SPD_LO        10
`define PSS_ENC_HI        9
`define PSS_ENC_LO        8
`define PSS_PHYLNK_BIT    7
`define PSS_UNK_BIT       6
`define PSS_DISP_BIT      5
`define PSS_INV_BIT       4
`define PSS_IDLE_BIT      3
`define PSS_CFG_BIT       2
`define PSS_SYNC_BIT      1
`define PSS_LINK_BIT      0
`define PSS_MAC_TRISPEED  4'h1
`define PSS_PHY_SGMII     4'h4
`define PSS_PHY_1000X     4'h5
`define PSS_IRQ_W         4
`define PSS_IRQ_FLT       0
`define PSS_IRQ_LINK      1
`define PSS_IRQ_SYNC      2
`define PSS_IRQ_ERR       3
`endif

// File: rtl/pss_pkg.sv
// types for the serial pcs status register block
package pss_pkg;
  typedef struct packed {
    logic       faultDetect;
    logic [1:0] faultCode;
    logic       fullDuplex;
    logic [1:0] speed;
    logic       phyLinked;
    logic       codeGroupUnknown;
    logic       disparityError;
    logic       orderedSetInvalid;
    logic       idleSetsSeen;
    logic       configSetsSeen;
    logic       syncAcquired;
    logic       anEnabled;
    logic       anComplete;
  } pss_pcs_t;
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } pss_req_t;
  typedef enum logic [1:0] {PssIdle, PssAnswer} pss_state_t;
endpackage

// File: rtl/pss_serial_pcs_status.sv
// serial pcs status register with avalon-mm slave and interrupt
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "pss_defines.svh"
module pss_serial_pcs_status
  import pss_pkg::*;
#(
  parameter logic [3:0] MAC_TYPE          = 4'h1,
  parameter logic [3:0] PHY_VARIANT_PARAM = 4'h5
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire pss_req_t    avReq,
  output logic [31:0]      avReaddata,
  output logic             avWaitrequest,
  input  wire pss_pcs_t    pcsIn,
  input  wire logic        phyStatusRead,
  output logic             irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  localparam logic VALID_BUILD = (MAC_TYPE == `PSS_MAC_TRISPEED) &&
    ((PHY_VARIANT_PARAM == `PSS_PHY_SGMII) ||
     (PHY_VARIANT_PARAM == `PSS_PHY_1000X));
  localparam logic IS_1000X = (PHY_VARIANT_PARAM == `PSS_PHY_1000X);

  logic [31:0]          status_q, status_d;
  logic                 fault_q, fault_d;
  logic [31:0]          readdata_q, readdata_d;
  pss_state_t           state_q, state_d;
  logic [`PSS_IRQ_W-1:0] intStat_q, intStat_d;
  logic [`PSS_IRQ_W-1:0] intMask_q, intMask_d;
  logic [`PSS_IRQ_W-1:0] event_v;
  logic                 link_q, sync_q;
  logic                 linkNow, syncNow;
  logic                 req, hit;

  assign syncNow = pcsIn.syncAcquired;
  assign linkNow = pcsIn.syncAcquired &&
                   (!pcsIn.anEnabled || pcsIn.anComplete);

  always_comb begin
    fault_d = fault_q;
    if (phyStatusRead)
      fault_d = 1'b0;
    if (IS_1000X && pcsIn.faultDetect)
      fault_d = 1'b1;
    status_d = 32'h0000_0000;
    if (VALID_BUILD) begin
      status_d[`PSS_FLT_BIT] = fault_q;
      status_d[`PSS_DUP_BIT] = pcsIn.fullDuplex;
      status_d[`PSS_SPD_HI:`PSS_SPD_LO] = pcsIn.speed;
      status_d[`PSS_ENC_HI:`PSS_ENC_LO] =
        IS_1000X ? pcsIn.faultCode : 2'h0;
      status_d[`PSS_PHYLNK_BIT] = !IS_1000X && pcsIn.phyLinked;
      status_d[`PSS_UNK_BIT]  = pcsIn.codeGroupUnknown;
      status_d[`PSS_DISP_BIT] = pcsIn.disparityError;
      status_d[`PSS_INV_BIT]  = pcsIn.orderedSetInvalid;
      status_d[`PSS_IDLE_BIT] = pcsIn.idleSetsSeen;
      status_d[`PSS_CFG_BIT]  = pcsIn.configSetsSeen;
      status_d[`PSS_SYNC_BIT] = syncNow;
      status_d[`PSS_LINK_BIT] = linkNow;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 32'h0000_0000;
      fault_q  <= 1'b0;
      link_q   <= 1'b0;
      sync_q   <= 1'b0;
    end else begin
      status_q <= status_d;
      fault_q  <= fault_d;
      link_q   <= status_q[`PSS_LINK_BIT];
      sync_q   <= status_q[`PSS_SYNC_BIT];
    end
  end

  // events: new fault, link change, sync change, decode error
  assign event_v[`PSS_IRQ_FLT]  = status_d[`PSS_FLT_BIT] &&
                                  !status_q[`PSS_FLT_BIT];
  assign event_v[`PSS_IRQ_LINK] = status_q[`PSS_LINK_BIT] != link_q;
  assign event_v[`PSS_IRQ_SYNC] = status_q[`PSS_SYNC_BIT] != sync_q;
  assign event_v[`PSS_IRQ_ERR]  = status_q[`PSS_UNK_BIT] ||
                                  status_q[`PSS_DISP_BIT] ||
                                  status_q[`PSS_INV_BIT];

  assign req = avReq.read || avReq.write;
  assign hit = (state_q == PssIdle) && req;

  // one wait cycle, answer on the second edge
  always_comb begin
    state_d    = state_q;
    readdata_d = readdata_q;
    intStat_d  = intStat_q;
    intMask_d  = intMask_q;
    case (state_q)
      PssIdle: begin
        if (req) begin
          state_d = PssAnswer;
          readdata_d = 32'h0000_0000;
          if (avReq.read) begin
            case (avReq.address)
              `PSS_STATUS_OFF:   readdata_d = status_q;
              `PSS_INT_STAT_OFF: readdata_d = {28'h0, intStat_q};
              `PSS_INT_MASK_OFF: readdata_d = {28'h0, intMask_q};
              default:           readdata_d = 32'h0000_0000;
            endcase
          end
        end
      end
      PssAnswer: begin
        state_d = PssIdle;
        if (avReq.write && avReq.address == `PSS_INT_STAT_OFF)
          intStat_d = intStat_q & ~avReq.writedata[`PSS_IRQ_W-1:0];
        if (avReq.write && avReq.address == `PSS_INT_MASK_OFF)
          intMask_d = avReq.writedata[`PSS_IRQ_W-1:0];
      end
      default: state_d = PssIdle;
    endcase
    intStat_d = intStat_d | event_v;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= PssIdle;
      readdata_q <= 32'h0000_0000;
      intStat_q  <= '0;
      intMask_q  <= '0;
    end else begin
      state_q    <= state_d;
      readdata_q <= readdata_d;
      intStat_q  <= intStat_d;
      intMask_q  <= intMask_d;
    end
  end

  assign avReaddata    = readdata_q;
  assign avWaitrequest = req && (state_q != PssAnswer);
  assign irq           = |(intStat_q & intMask_q);

  // write strobes of the interrupt registers, answer cycle only
  logic                 wrStat, wrMask;
  assign wrStat = (state_q == PssAnswer) && avReq.write &&
                  (avReq.address == `PSS_INT_STAT_OFF);
  assign wrMask = (state_q == PssAnswer) && avReq.write &&
                  (avReq.address == `PSS_INT_MASK_OFF);

  // status word
  reserved_zero_a: assert property (
    status_q[31:14] == 18'h0)
    else $error("reserved bits set");

  off_zero_a: assert property (
    !VALID_BUILD |-> status_q == 32'h0000_0000)
    else $error("status not zero in unsupported build");

  fault_set_a: assert property (
    VALID_BUILD && IS_1000X && pcsIn.faultDetect |->
    ##2 status_q[`PSS_FLT_BIT])
    else $error("fault bit missed");

  fault_sticky_a: assert property (
    fault_q && !phyStatusRead |=> fault_q)
    else $error("fault cleared without read");

  fault_clear_a: assert property (
    phyStatusRead && !pcsIn.faultDetect |=> !fault_q)
    else $error("fault not cleared");

  fault_sgmii_a: assert property (
    !IS_1000X |-> !fault_q && !status_q[`PSS_FLT_BIT])
    else $error("fault set in sgmii mode");

  duplex_follow_a: assert property (
    VALID_BUILD |=> status_q[`PSS_DUP_BIT] == $past(pcsIn.fullDuplex))
    else $error("duplex not followed");

  speed_follow_a: assert property (
    VALID_BUILD |=>
    status_q[`PSS_SPD_HI:`PSS_SPD_LO] == $past(pcsIn.speed))
    else $error("speed not followed");

  code_follow_a: assert property (
    VALID_BUILD && IS_1000X |=>
    status_q[`PSS_ENC_HI:`PSS_ENC_LO] == $past(pcsIn.faultCode))
    else $error("fault code not followed");

  phy_link_a: assert property (
    VALID_BUILD && !IS_1000X |=>
    status_q[`PSS_PHYLNK_BIT] == $past(pcsIn.phyLinked))
    else $error("phy link not followed");

  phy_low_a: assert property (
    IS_1000X |-> !status_q[`PSS_PHYLNK_BIT])
    else $error("phy link high in 1000x");

  unknown_follow_a: assert property (
    VALID_BUILD |=>
    status_q[`PSS_UNK_BIT] == $past(pcsIn.codeGroupUnknown))
    else $error("unknown code bit not followed");

  disparity_follow_a: assert property (
    VALID_BUILD |=>
    status_q[`PSS_DISP_BIT] == $past(pcsIn.disparityError))
    else $error("disparity bit not followed");

  invalid_follow_a: assert property (
    VALID_BUILD |=>
    status_q[`PSS_INV_BIT] == $past(pcsIn.orderedSetInvalid))
    else $error("invalid set bit not followed");

  idle_follow_a: assert property (
    VALID_BUILD |=>
    status_q[`PSS_IDLE_BIT] == $past(pcsIn.idleSetsSeen))
    else $error("idle bit not followed");

  config_follow_a: assert property (
    VALID_BUILD |=>
    status_q[`PSS_CFG_BIT] == $past(pcsIn.configSetsSeen))
    else $error("config bit not followed");

  sync_follow_a: assert property (
    VALID_BUILD |=>
    status_q[`PSS_SYNC_BIT] == $past(pcsIn.syncAcquired))
    else $error("sync not followed");

  link_follow_a: assert property (
    VALID_BUILD |=> status_q[`PSS_LINK_BIT] ==
    $past(pcsIn.syncAcquired && (!pcsIn.anEnabled || pcsIn.anComplete)))
    else $error("link not followed");

  link_valid_a: assert property (
    status_q[`PSS_LINK_BIT] |-> status_q[`PSS_SYNC_BIT])
    else $error("link without sync");

  // register bus
  wait_first_a: assert property (
    hit |-> avWaitrequest)
    else $error("request answered without wait");

  answer_time_a: assert property (
    hit |=> !avWaitrequest)
    else $error("slave answer late");

  wait_idle_a: assert property (
    !req |-> !avWaitrequest)
    else $error("wait without request");

  data_hold_a: assert property (
    !hit |=> $stable(avReaddata))
    else $error("read data changed without request");

  status_read_a: assert property (
    hit && avReq.read && avReq.address == `PSS_STATUS_OFF |=>
    avReaddata == $past(status_q))
    else $error("status read wrong");

  stat_read_a: assert property (
    hit && avReq.read && avReq.address == `PSS_INT_STAT_OFF |=>
    avReaddata == {28'h0, $past(intStat_q)})
    else $error("interrupt status read wrong");

  mask_read_a: assert property (
    hit && avReq.read && avReq.address == `PSS_INT_MASK_OFF |=>
    avReaddata == {28'h0, $past(intMask_q)})
    else $error("interrupt mask read wrong");

  unmapped_zero_a: assert property (
    hit && avReq.read && avReq.address != `PSS_STATUS_OFF &&
    avReq.address != `PSS_INT_STAT_OFF &&
    avReq.address != `PSS_INT_MASK_OFF |=> avReaddata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // interrupt registers
  mask_write_a: assert property (
    wrMask |=> intMask_q == $past(avReq.writedata[`PSS_IRQ_W-1:0]))
    else $error("mask write lost");

  mask_hold_a: assert property (
    !wrMask |=> $stable(intMask_q))
    else $error("mask changed without write");

  irq_level_a: assert property (
    irq == |(intStat_q & intMask_q))
    else $error("irq mismatch");

  irq_low_a: assert property (
    intMask_q == '0 |-> !irq)
    else $error("irq high with all masked");

  for (genvar i = 0; i < `PSS_IRQ_W; i++) begin : g_stat
    stat_set_a: assert property (
      event_v[i] |=> intStat_q[i])
      else $error("interrupt event lost");

    stat_hold_a: assert property (
      intStat_q[i] && !(wrStat && avReq.writedata[i]) |=> intStat_q[i])
      else $error("interrupt status dropped");

    stat_clear_a: assert property (
      wrStat && avReq.writedata[i] && !event_v[i] |=> !intStat_q[i])
      else $error("interrupt status not cleared");
  end

  read_cov_c: cover property (
    avReq.read && !avWaitrequest);

  write_cov_c: cover property (
    avReq.write && !avWaitrequest);

  fault_cov_c: cover property (
    $rose(fault_q));

  link_cov_c: cover property (
    $rose(status_q[`PSS_LINK_BIT]));

  irq_cov_c: cover property (
    $rose(irq));
endmodule

// File: tb/pss_pcs_model.sv
// behavioural model of the coding sublayer and management side
`timescale 1ns/100ps
module pss_pcs_model
  import pss_pkg::*;
(
  input  wire logic clk,
  output pss_pcs_t  pcsOut,
  output logic      phyStatusRead
);
  initial begin
    pcsOut = '0;
    phyStatusRead = 1'b0;
  end
  // level state of the sublayer, held until changed
  task automatic setPcs(input pss_pcs_t v);
    pcsOut <= v;
  endtask
  // one-cycle management read of phy status register 1
  task automatic mgmtRead();
    phyStatusRead <= 1'b1;
    @(posedge clk);
    phyStatusRead <= 1'b0;
  endtask
endmodule

// File: tb/pss_serial_pcs_status_tb.sv
// testbench for the serial pcs status register block
`timescale 1ns/100ps
`include "pss_defines.svh"
module pss_serial_pcs_status_tb
  import pss_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  pss_req_t    avReq;
  pss_pcs_t    pcsIn;
  pss_pcs_t    p;
  logic [31:0] rdX, rdS, rdN, rX, rS, rN;
  logic        wrX, irqX, phyRd;
  int          mismatches = 0;
  int          checked = 0;
  always #20 clk = ~clk;
  pss_pcs_model pss_pcs_model_i (.clk(clk), .pcsOut(pcsIn),
    .phyStatusRead(phyRd));
  pss_serial_pcs_status
    pss_serial_pcs_status_i (.clk(clk), .rst_n(rst_n), .avReq(avReq),
    .avReaddata(rdX), .avWaitrequest(wrX), .pcsIn(pcsIn),
    .phyStatusRead(phyRd), .irq(irqX));
  pss_serial_pcs_status #(.MAC_TYPE(4'h1), .PHY_VARIANT_PARAM(4'h4))
    pss_serial_pcs_status_sg_i (.clk(clk), .rst_n(rst_n), .avReq(avReq),
    .avReaddata(rdS), .avWaitrequest(), .pcsIn(pcsIn),
    .phyStatusRead(phyRd), .irq());
  pss_serial_pcs_status #(.MAC_TYPE(4'h2), .PHY_VARIANT_PARAM(4'h5))
    pss_serial_pcs_status_off_i (.clk(clk), .rst_n(rst_n), .avReq(avReq),
    .avReaddata(rdN), .avWaitrequest(), .pcsIn(pcsIn),
    .phyStatusRead(phyRd), .irq());
  task automatic report_and_stop();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic busOp(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
    int n;
    n = 0;
    avReq.address <= a;
    avReq.read <= ~w;
    avReq.write <= w;
    avReq.writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wrX !== 1'b0 && n < 50);
    if (wrX !== 1'b0) begin
      mismatches++;
      report_and_stop();
    end
    rX = rdX;
    rS = rdS;
    rN = rdN;
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chkIrq(input logic e);
    @(negedge clk);
    chk({31'h0, irqX}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic put(input pss_pcs_t v);
    pss_pcs_model_i.setPcs(v);
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] expSt(pss_pcs_t v, logic sg, logic f);
    expSt = {18'h0, f, v.fullDuplex, v.speed, sg ? 2'h0 : v.faultCode,
      sg & v.phyLinked, v.codeGroupUnknown, v.disparityError,
      v.orderedSetInvalid, v.idleSetsSeen, v.configSetsSeen,
      v.syncAcquired, v.syncAcquired & (!v.anEnabled | v.anComplete)};
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    avReq = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    busOp(`PSS_STATUS_OFF, 1'b0, 32'h0);
    chk(rX, 32'h0);
    chkIrq(1'b0);
    for (int i = 0; i < 4; i++) begin
      p = '0;
      p.fullDuplex = 1'b1;
      p.speed = i[1:0];
      {p.codeGroupUnknown, p.disparityError, p.orderedSetInvalid} = 3'h1 << i;
      p.idleSetsSeen = i[0];
      p.configSetsSeen = ~i[0];
      p.syncAcquired = (i != 2);
      p.phyLinked = i[1];
      p.anEnabled = (i != 3);
      p.anComplete = (i == 1);
      put(p);
      busOp(`PSS_STATUS_OFF, 1'b0, 32'h0);
      chk(rX, expSt(p, 1'b0, 1'b0));
      chk(rS & ~32'h2000, expSt(p, 1'b1, 1'b0));
      chk(rN, 32'h0);
    end
    put('0);
    busOp(`PSS_INT_MASK_OFF, 1'b1, 32'h1);
    busOp(`PSS_INT_MASK_OFF, 1'b0, 32'h0);
    chk(rX, 32'h1);
    busOp(`PSS_INT_STAT_OFF, 1'b1, 32'hF);
    chkIrq(1'b0);
    p = '0;
    p.faultDetect = 1'b1;
    p.faultCode = 2'h2;
    put(p);
    p.faultDetect = 1'b0;
    put(p);
    busOp(`PSS_STATUS_OFF, 1'b0, 32'h0);
    chk(rX, expSt(p, 1'b0, 1'b1));
    busOp(`PSS_INT_STAT_OFF, 1'b0, 32'h0);
    chk(rX, 32'h1);
    chkIrq(1'b1);
    busOp(`PSS_INT_MASK_OFF, 1'b1, 32'h0);
    chkIrq(1'b0);
    busOp(`PSS_INT_MASK_OFF, 1'b1, 32'h1);
    busOp(`PSS_INT_STAT_OFF, 1'b1, 32'h1);
    chkIrq(1'b0);
    pss_pcs_model_i.mgmtRead();
    repeat (3) @(posedge clk);
    busOp(`PSS_STATUS_OFF, 1'b1, 32'hFFFFFFFF);
    busOp(`PSS_STATUS_OFF, 1'b0, 32'h0);
    chk(rX, expSt(p, 1'b0, 1'b0));
    busOp(8'h3C, 1'b0, 32'h0);
    chk(rX, 32'h0);
    p = '0;
    p.syncAcquired = 1'b1;
    p.codeGroupUnknown = 1'b1;
    put(p);
    busOp(`PSS_INT_STAT_OFF, 1'b0, 32'h0);
    chk(rX, 32'hE);
    busOp(`PSS_INT_STAT_OFF, 1'b1, 32'hF);
    busOp(`PSS_INT_STAT_OFF, 1'b0, 32'h0);
    chk(rX, 32'h8);
    report_and_stop();
  end
endmodule
